// file: verilog/adc_port_consts.svh
// timing counts and field layout constants for the serial converter port
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH
`define RES_BITS 14
`define TRACK_EDGE 16
`define NAP_STROBES 2
`define SLEEP_STROBES 4
`define CODE_ALL_ONES 14'h3fff
`define CODE_ALL_ZEROS 14'h0000
`endif

// file: verilog/adc_port_pkg.sv
// types shared by the serial converter port
package adc_port_pkg;
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_NAP,
      PWR_SLEEP
   } power_state_t;
   typedef struct packed {
      logic [13:0] code;
      logic over_range;
      logic under_range;
   } sample_t;
   typedef struct packed {
      logic data;
      logic oe;
   } tri_pin_t;
endpackage

// file: verilog/adc_port.sv
// digital side of a three-wire serial sampling converter
`timescale 1ns/100ps
`include "adc_port_consts.svh"
// Operation
// - convert strobe rise holds input, starts conversion
// - shift clock rise steps conversion, shifts bit
// - three-state output carries previous conversion's sample
// - two strobes, clock still, enter nap
// - four or more strobes, clock still, sleep
// - shift clock pulse wakes from sleep
// - saturate code above full scale, below zero
// - fourteen bits msb first, hi-z around word
// - ignore strobes until sixteen clock rises
// - straight unsigned binary, zero gives zeros
// - acquisition from sixteenth clock to next strobe
module adc_port #(
   parameter int RES_BITS = `RES_BITS,
   parameter int TRACK_EDGE = `TRACK_EDGE
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_shift_clk,
   input wire logic i_convert_strobe,
   input wire logic [13:0] i_sample_code,
   input wire logic i_over_range,
   input wire logic i_under_range,
   output logic o_serial_result_out,
   output logic o_serial_result_oe,
   output logic o_tracking,
   output logic o_nap,
   output logic o_sleep
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sck_sync_ff; // [0] first stage, read only by [1]
   logic [1:0] cnv_sync_ff;
   logic sck_last_ff; // previous synchronised level
   logic cnv_last_ff;
   logic sck_rise;
   logic cnv_rise;

   // two flops per pin; both pins come from the controller's domain
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sck_sync_ff <= 2'h0;
         cnv_sync_ff <= 2'h0;
         sck_last_ff <= 1'b0;
         cnv_last_ff <= 1'b0;
      end else begin
         sck_sync_ff <= {sck_sync_ff[0], i_shift_clk};
         cnv_sync_ff <= {cnv_sync_ff[0], i_convert_strobe};
         sck_last_ff <= sck_sync_ff[1];
         cnv_last_ff <= cnv_sync_ff[1];
      end
   end

   assign sck_rise = sck_sync_ff[1] & ~sck_last_ff;
   assign cnv_rise = cnv_sync_ff[1] & ~cnv_last_ff;

   // ----------------------------------------------------------------
   // sample hold and code saturation
   // ----------------------------------------------------------------
   adc_port_pkg::sample_t held_ff; // frozen at strobe
   logic [13:0] sat_code; // clamped code of the frozen sample
   logic busy_ff; // conversion running, strobes ignored
   logic [4:0] edge_cnt_ff; // shift clock rises since strobe

   // out of range inputs override the converted value
   always_comb begin
      if (held_ff.over_range) begin
         sat_code = `CODE_ALL_ONES;
      end else if (held_ff.under_range) begin
         sat_code = `CODE_ALL_ZEROS;
      end else begin
         sat_code = held_ff.code; // straight binary passes through
      end
   end

   // freeze the input on an accepted strobe
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         held_ff <= '0;
      end else if (cnv_rise && !busy_ff) begin
         held_ff.code <= i_sample_code;
         held_ff.over_range <= i_over_range;
         held_ff.under_range <= i_under_range;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencing
   // ----------------------------------------------------------------
   // busy from an accepted strobe until the sixteenth clock rise
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_ff <= 1'b0;
         edge_cnt_ff <= 5'h00;
      end else if (cnv_rise && !busy_ff) begin
         busy_ff <= 1'b1;
         edge_cnt_ff <= 5'h00;
      end else if (busy_ff && sck_rise) begin
         // each clock rise steps the conversion
         if (edge_cnt_ff == 5'(TRACK_EDGE - 1)) begin
            busy_ff <= 1'b0; // strobes accepted again
         end
         edge_cnt_ff <= edge_cnt_ff + 5'h01;
      end
   end

   // tracking window: sixteenth clock rise to next strobe
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tracking <= 1'b1; // active and tracking after power-up
      end else if (cnv_rise && !busy_ff) begin
         o_tracking <= 1'b0;
      end else if (busy_ff && sck_rise &&
                   edge_cnt_ff == 5'(TRACK_EDGE - 1)) begin
         o_tracking <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // serial output shifter
   // ----------------------------------------------------------------
   logic [13:0] shift_ff; // word being shifted out

   // the word shifted now is the one converted last time round;
   // a latency of one frame, as a pipelined converter shows.
   // at the accepting edge held_ff still carries the sample frozen
   // by the previous strobe, so its clamped code is loaded here,
   // and held_ff takes the new sample at the same edge.
   // a second pipeline stage would add a frame of latency,
   // so the clamped code goes straight into the shifter.
   // the first word after reset is all zeros, since held_ff
   // resets to zero and the clamp passes zero through.
   // limitation: a strobe refused while busy never refreshes
   // the held sample, so the controller must keep the spacing.
   // trade-off: loading the whole word at the strobe costs one
   // fourteen-bit register but keeps the bit path a single mux.
   // the bit after the first is read from bit twelve, because
   // the shift into position thirteen lands at the same edge.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_ff <= 14'h0000;
      end else if (cnv_rise && !busy_ff) begin
         shift_ff <= sat_code;
      end else if (busy_ff && sck_rise && edge_cnt_ff != 5'h00) begin
         shift_ff <= {shift_ff[12:0], 1'b0}; // msb first
      end
   end

   // drive bits on rises 1..14, release the pin otherwise
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_serial_result_oe <= 1'b0;
         o_serial_result_out <= 1'b0;
      end else if (busy_ff && sck_rise) begin
         if (edge_cnt_ff < 5'(RES_BITS)) begin
            o_serial_result_oe <= 1'b1;
            o_serial_result_out <= (edge_cnt_ff == 5'h00) ?
               shift_ff[13] : shift_ff[12]; // next bit
         end else begin
            o_serial_result_oe <= 1'b0; // hi-z after word
            o_serial_result_out <= 1'b0;
         end
      end else if (!busy_ff) begin
         o_serial_result_oe <= 1'b0; // hi-z before word
         o_serial_result_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // power-down control
   // ----------------------------------------------------------------
   adc_port_pkg::power_state_t pwr_ff;
   logic [2:0] idle_strobes_ff; // strobes with clock held still

   // count strobes with no clock rise between; saturate at four.
   // the strobe that started the conversion counts as the first.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         idle_strobes_ff <= 3'h0;
      end else if (sck_rise) begin
         idle_strobes_ff <= 3'h0;
      end else if (cnv_rise && idle_strobes_ff != 3'(`SLEEP_STROBES)) begin
         idle_strobes_ff <= idle_strobes_ff + 3'h1;
      end
   end

   // power state follows the strobe count; clock rise wakes
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pwr_ff <= adc_port_pkg::PWR_ACTIVE;
      end else if (sck_rise) begin
         pwr_ff <= adc_port_pkg::PWR_ACTIVE;
      end else if (cnv_rise) begin
         if (idle_strobes_ff >= 3'(`SLEEP_STROBES - 1)) begin
            pwr_ff <= adc_port_pkg::PWR_SLEEP;
         end else if (idle_strobes_ff == 3'(`NAP_STROBES - 1)) begin
            pwr_ff <= adc_port_pkg::PWR_NAP;
         end
      end
   end

   // registered status outputs
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_nap <= 1'b0;
         o_sleep <= 1'b0;
      end else begin
         o_nap <= (pwr_ff == adc_port_pkg::PWR_NAP);
         o_sleep <= (pwr_ff == adc_port_pkg::PWR_SLEEP);
      end
   end

endmodule

// file: test/adc_port_monitor.sv
// pin-level assertions for the serial converter port
`timescale 1ns/100ps
module adc_port_monitor #(
   parameter int RES_BITS = 14,
   parameter int TRACK_EDGE = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_shift_clk,
   input wire logic i_convert_strobe,
   input wire logic [13:0] i_sample_code,
   input wire logic i_over_range,
   input wire logic i_under_range,
   input wire logic o_serial_result_out,
   input wire logic o_serial_result_oe,
   input wire logic o_tracking,
   input wire logic o_nap,
   input wire logic o_sleep
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // released pin shows low, never a stale bit
   property p_oz; !o_serial_result_oe |-> !o_serial_result_out; endproperty
   a_oz: assert property (p_oz) else $error("data while off");
   property p_trk; o_tracking |-> !o_serial_result_oe; endproperty
   a_trk: assert property (p_trk) else $error("drive in acquire");
   property p_hold;
      $fell(o_tracking) |-> $past(i_convert_strobe, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("hold no strobe");
   // a new bit only follows a shift clock rise
   property p_step;
      o_serial_result_oe && $past(o_serial_result_oe)
         && $changed(o_serial_result_out) |-> $past(i_shift_clk, 3);
   endproperty
   a_step: assert property (p_step) else $error("bit moved alone");
   property p_word; $rose(o_serial_result_oe) |-> !o_tracking; endproperty
   a_word: assert property (p_word) else $error("word outside convert_strobe");
   property p_acq; $rose(o_tracking) |-> $past(i_shift_clk, 3); endproperty
   a_acq: assert property (p_acq) else $error("track no clock");
   property p_nap; $rose(o_nap) |-> $past(i_convert_strobe, 3); endproperty
   a_nap: assert property (p_nap) else $error("nap no strobe");
   property p_slp;
      $rose(o_sleep) |-> $past(i_convert_strobe, 3) && !o_serial_result_oe;
   endproperty
   a_slp: assert property (p_slp) else $error("bad sleep entry");
   property p_wake; $rose(i_shift_clk) |-> ##[1:6] !o_nap && !o_sleep;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   c_nap: cover property ($rose(o_nap));
   c_slp: cover property ($rose(o_sleep));
   c_word: cover property ($fell(o_serial_result_oe));
endmodule
bind adc_port adc_port_monitor #(.RES_BITS(RES_BITS), .TRACK_EDGE(TRACK_EDGE))
   i_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_shift_clk(i_shift_clk),
   .i_convert_strobe(i_convert_strobe), .i_sample_code(i_sample_code),
   .i_over_range(i_over_range), .i_under_range(i_under_range),
   .o_serial_result_out(o_serial_result_out),
   .o_serial_result_oe(o_serial_result_oe), .o_tracking(o_tracking),
   .o_nap(o_nap), .o_sleep(o_sleep));

// file: test/adc_ctrl_model.sv
// controller model: makes strobe and shift clock, reads the word
`timescale 1ns/100ps
module adc_ctrl_model (
   input wire logic i_data,
   input wire logic i_oe,
   output logic o_shift_clk,
   output logic o_convert_strobe
);
   // clock stands still low outside frames
   initial begin
      o_shift_clk = 1'b0;
      o_convert_strobe = 1'b0;
   end
   // one strobe pulse with the clock held
   task pulse();
      o_convert_strobe = 1'b1;
      #200 o_convert_strobe = 1'b0;
      #200;
   endtask
   // n shift pulses, 400 ns period
   task clocks(input int n);
      repeat (n) begin
         o_shift_clk = 1'b1;
         #200 o_shift_clk = 1'b0;
         #200;
      end
   endtask
   // strobe then 17 rises, bits caught on rises 2..15
   task frame(input int mid, output logic [13:0] w, output int bad);
      bad = 0;
      pulse();
      for (int i = 1; i <= 17; i++) begin
         o_shift_clk = 1'b1;
         if (i > 1 && i < 16) w = {w[12:0], i_data};
         if (i_oe !== (i > 1 && i < 16)) bad++;
         #200 o_shift_clk = 1'b0;
         if (i == mid) o_convert_strobe = 1'b1; // strobe while busy
         #200 o_convert_strobe = 1'b0;
      end
   endtask
endmodule

// file: test/tb_adc_port.sv
// self-checking bench for the serial converter port
`timescale 1ns/100ps
module tb_adc_port;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [13:0] code = 14'h0000;
   logic ovr = 1'b0;
   logic und = 1'b0;
   logic shift_clk, strobe, serial_result_out, sdo_oe, tracking, nap, sleep;
   logic [13:0] w, prev;
   int bad, fail_count = 0, total_checks = 0;
   // code, over, under, then the word it should give
   logic [29:0] rows [7] = '{{14'h1234, 2'b00, 14'h1234},
      {14'h0000, 2'b00, 14'h0000}, {14'h1555, 2'b10, 14'h3fff},
      {14'h2aaa, 2'b01, 14'h0000}, {14'h3fff, 2'b00, 14'h3fff},
      {14'h0001, 2'b00, 14'h0001}, {14'h2000, 2'b11, 14'h3fff}};
   adc_port i_adc_port (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_shift_clk(shift_clk), .i_convert_strobe(strobe),
      .i_sample_code(code), .i_over_range(ovr), .i_under_range(und),
      .o_serial_result_out(serial_result_out), .o_serial_result_oe(sdo_oe),
      .o_tracking(tracking), .o_nap(nap), .o_sleep(sleep));
   adc_ctrl_model i_adc_ctrl_model (.i_data(serial_result_out), .i_oe(sdo_oe),
      .o_shift_clk(shift_clk), .o_convert_strobe(strobe));
   initial forever #25 i_mclk = ~i_mclk;
   task check(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_mclk);
      #1 i_rst_b = 1'b1;
      repeat (4) @(posedge i_mclk);
      #1 check(14'({sdo_oe, tracking, nap, sleep}), 14'h4);
      $display("reset test done");
      prev = 14'h0000;
      // word out is the one held at the previous strobe
      foreach (rows[k]) begin
         {code, ovr, und} = rows[k][29:14];
         i_adc_ctrl_model.frame(0, w, bad);
         check(w, prev);
         check(14'(bad), 14'h0000);
         prev = rows[k][13:0];
         $display("row %0d done", k);
      end
      {code, ovr, und} = {14'h0abc, 2'b00};
      i_adc_ctrl_model.frame(8, w, bad);
      check(14'(bad), 14'h0000);
      check(w, 14'h3fff);
      i_adc_ctrl_model.frame(0, w, bad);
      check(w, 14'h0abc);
      $display("busy strobe test done");
      i_adc_ctrl_model.pulse();
      i_adc_ctrl_model.pulse();
      check(14'({nap, sleep}), 14'h0002);
      i_adc_ctrl_model.pulse();
      i_adc_ctrl_model.pulse();
      check(14'(sleep), 14'h0001);
      i_adc_ctrl_model.clocks(1);
      check(14'({nap, sleep}), 14'h0000);
      i_adc_ctrl_model.clocks(16);
      i_adc_ctrl_model.pulse();
      i_adc_ctrl_model.clocks(1);
      i_adc_ctrl_model.pulse();
      check(14'(nap), 14'h0000);
      $display("power test done");
      complete_run();
   end
endmodule
